// file: ram_port_pkg.sv
// Package with register map, field layout and carrier types for the RAM port block.
package ram_port_pkg;

  localparam int unsigned ADDR_W = 8;

  localparam logic [7:0] OFS_PORT_SELECT  = 8'h40;
  localparam logic [7:0] OFS_PORT_COMMAND = 8'h44;
  localparam logic [7:0] OFS_WORD_ADDRESS = 8'h48;
  localparam logic [7:0] OFS_DATA_LOW     = 8'h4c;
  localparam logic [7:0] OFS_DATA_HIGH    = 8'h50;
  localparam logic [7:0] OFS_PIN_WAKE     = 8'h64;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h68;

  localparam int unsigned WORD_ADDR_W = 15;
  localparam int unsigned HIGH_DATA_W = 5;
  localparam int unsigned RAM_DATA_W  = 37;
  localparam int unsigned PIN_COUNT   = 11;

  localparam int unsigned SEL_IDLE_BIT  = 31;
  localparam int unsigned SEL_TARGET_LO = 1;
  localparam int unsigned SEL_ENABLE_BIT = 0;
  localparam int unsigned CMD_WRITE_BIT = 0;

  localparam int unsigned WAKE_POL_LO = 16;
  localparam int unsigned WAKE_EN_LO  = 0;

  localparam int unsigned IRQ_ALWAYS_BIT   = 31;
  localparam int unsigned IRQ_MACRTO_BIT   = 19;
  localparam int unsigned IRQ_RXFRAME_BIT  = 18;
  localparam int unsigned IRQ_TXSTOP_BIT   = 17;
  localparam int unsigned IRQ_RXSTOP_BIT   = 16;
  localparam int unsigned IRQ_PHY_BIT      = 15;
  localparam int unsigned IRQ_TXERR_BIT    = 14;
  localparam int unsigned IRQ_UNDERRUN_BIT = 13;
  localparam int unsigned IRQ_OVERRUN_BIT  = 12;
  localparam int unsigned IRQ_RXDROP_BIT   = 11;
  localparam int unsigned IRQ_EVENT_W      = 20;

  localparam logic [14:0] RST_WORD_ADDRESS = 15'h0000;
  localparam logic [31:0] RST_DATA_LOW     = 32'h0000_0000;
  localparam logic [4:0]  RST_DATA_HIGH    = 5'h00;
  localparam logic [19:0] RST_IRQ_MASK     = 20'h00000;
  localparam logic [1:0]  RST_TARGET       = 2'h0;
  localparam logic [21:0] RST_WAKE_BLANK   = 22'h000000;
  localparam logic [31:0] BUS_ERR_DATA     = 32'h0000_0000;

  typedef enum logic [1:0] {
    RAM_FRAME_CONTROL,
    RAM_EEPROM_STORE,
    RAM_TX_TRANSFER_LINK,
    RAM_RX_TRANSFER_LINK
  } ram_target_e;

  typedef struct packed {
    logic              req;
    logic              write;
    ram_target_e       target;
    logic [14:0]       addr;
    logic [36:0]       wdata;
  } ram_req_s;

  typedef struct packed {
    logic              done;
    logic [36:0]       rdata;
  } ram_rsp_s;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [7:0]        adr;
    logic [31:0]       dat;
  } wb_req_s;

  typedef struct packed {
    logic              ack;
    logic              err;
    logic [31:0]       dat;
  } wb_rsp_s;

endpackage

// file: wake_pin_gate.sv
// Per-pin wake detection gated by enable, polarity and general purpose mode.
module wake_pin_gate #(
  parameter int unsigned PINS = 11
) (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // Pin levels already synchronised, and configuration.
  input  wire logic [PINS-1:0]   pin_level,
  input  wire logic [PINS-1:0]   pin_is_gpio,
  input  wire logic [PINS-1:0]   wake_enable,
  input  wire logic [PINS-1:0]   wake_polarity,
  // Registered wake result.
  output logic      [PINS-1:0]   wake_hit_ff
);

  logic [PINS-1:0] nxt_wake_hit;

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      assign nxt_wake_hit[g] = pin_is_gpio[g] & wake_enable[g] &
                               ~(pin_level[g] ^ wake_polarity[g]);
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wake_hit_ff <= '0;
    end else begin
      wake_hit_ff <= nxt_wake_hit;
    end
  end

endmodule

// file: ram_port_access.sv
// Sequencer that carries one data port access to the selected internal RAM.
module ram_port_access (
  // Clock and reset.
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  // Start of an access from the register bank.
  input  wire logic                   start,
  input  wire logic                   start_write,
  // RAM side.
  output ram_port_pkg::ram_req_s      ram_req_ff,
  input  wire ram_port_pkg::ram_rsp_s ram_rsp,
  // Completion to the register bank.
  output logic                        busy_ff,
  output logic                        read_done_ff
);
  import ram_port_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} seq_e;

  seq_e state_ff;
  logic is_write_ff;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff     <= ST_IDLE;
      busy_ff      <= 1'b0;
      is_write_ff  <= 1'b0;
      read_done_ff <= 1'b0;
      ram_req_ff   <= '0;
    end else begin
      read_done_ff   <= 1'b0;
      ram_req_ff.req <= 1'b0;
      unique case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff       <= ST_WAIT;
            busy_ff        <= 1'b1;
            is_write_ff    <= start_write;
            ram_req_ff.req <= 1'b1;
            ram_req_ff.write <= start_write;
          end
        end
        ST_WAIT: begin
          if (ram_rsp.done) begin
            state_ff     <= ST_IDLE;
            busy_ff      <= 1'b0;
            read_done_ff <= ~is_write_ff;
          end
        end
      endcase
    end
  end

endmodule

// file: ram_port_and_irq_report_regs.sv
// Wishbone register bank for the RAM data port, pin wake and interrupt report mask.
//
// Overview of operation
// - Word address is 15 bits, counted in 37-bit RAM words.
// - Low data register holds write data and receives 32-bit read result.
// - While busy the access is in progress and data is not updated.
// - High data register bits 4:0 carry RAM bits 36:32.
// - Wake register holds per-pin wake enables and detection polarity.
// - A pin not in general purpose mode never wakes the device.
// - Wake field defaults from the EEPROM image, zero without EEPROM.
// - USB or lite reset restores the wake field to the EEPROM image.
// - Bit 31 set sends a packet every interval, else on enabled events.
// - Event enables reset to zero; one lets the event trigger a packet.
// - Bit 19 gates MAC reset timeout, bit 18 receive frame present.
// - Bit 17 gates transmitter stopped, bit 16 receiver stopped.
// - Bit 15 PHY, 14 transmit error, 13 underrun, 12 overrun.
// - Bit 11 gates dropped frames, bits 10:0 the eleven pins.
// - Ready bit 31 of select reads zero while busy, resets to one.
// - Writing command bit 0 starts an access, one write, zero read.
//
// The implementer's own choice: register access over Wishbone.
module ram_port_and_irq_report_regs #(
  parameter int unsigned PINS = 11
) (
  // Clock and reset.
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  // USB reset or lite reset request, one cycle, same clock.
  input  wire logic                   usb_or_lite_reset,
  // Wishbone slave.
  input  wire ram_port_pkg::wb_req_s  wb_req,
  output ram_port_pkg::wb_rsp_s       wb_rsp_ff,
  // EEPROM image of the wake field.
  input  wire logic                   eeprom_present,
  input  wire logic                   eeprom_loaded,
  input  wire logic [31:0]            eeprom_wake_image,
  // Internal RAM access.
  output ram_port_pkg::ram_req_s      ram_req_ff,
  input  wire ram_port_pkg::ram_rsp_s ram_rsp,
  output logic                        ram_test_access_enable_ff,
  // Pins, asynchronous to this clock.
  input  wire logic [PINS-1:0]        pin_level,
  input  wire logic [PINS-1:0]        pin_is_gpio,
  output logic      [PINS-1:0]        wake_hit_ff,
  output logic                        wake_event_ff,
  // Interrupt report sources, same clock, level.
  input  wire logic [8:0]             mac_events,
  input  wire logic                   irq_interval_tick,
  output logic                        irq_packet_send_ff,
  output logic      [19:0]            irq_report_sources_ff
);
  import ram_port_pkg::*;

  logic [14:0]     word_addr_ff;
  logic [31:0]     data_low_ff;
  logic [4:0]      data_high_ff;
  logic [1:0]      target_ff;
  logic            irq_packet_always_send_ff;
  logic [19:0]     irq_gates_ff;
  logic [PINS-1:0] wake_en_ff;
  logic [PINS-1:0] wake_pol_ff;
  logic [PINS-1:0] wake_en_img_ff;
  logic [PINS-1:0] wake_pol_img_ff;
  logic [PINS-1:0] pin_meta_ff;
  logic [PINS-1:0] pin_sync_ff;
  logic            port_busy;
  logic [PINS-1:0] wake_hit;
  ram_req_s        seq_req;

  // Bus decode.
  wire access    = wb_req.cyc & wb_req.stb & ~wb_rsp_ff.ack & ~wb_rsp_ff.err;
  wire wr        = access & wb_req.we & (&wb_req.sel);
  wire hit_sel   = wb_req.adr == OFS_PORT_SELECT;
  wire hit_cmd   = wb_req.adr == OFS_PORT_COMMAND;
  wire hit_addr  = wb_req.adr == OFS_WORD_ADDRESS;
  wire hit_low   = wb_req.adr == OFS_DATA_LOW;
  wire hit_high  = wb_req.adr == OFS_DATA_HIGH;
  wire hit_wake  = wb_req.adr == OFS_PIN_WAKE;
  wire hit_mask  = wb_req.adr == OFS_IRQ_MASK;
  wire mapped    = hit_sel | hit_cmd | hit_addr | hit_low | hit_high | hit_wake | hit_mask;
  // Port register writes during a running access would corrupt it, so they are dropped; wake and mask writes still land.
  wire wr_ok     = wr & ~port_busy;
  wire start     = wr_ok & hit_cmd & ram_test_access_enable_ff;
  wire start_wr  = wb_req.dat[CMD_WRITE_BIT];
  // Read data is valid only together with done, so it is caught in that very cycle.
  wire read_capture = port_busy & ram_rsp.done & ~ram_req_ff.write;

  wire [31:0] rd_sel  = {~port_busy, 28'h0000000, target_ff, ram_test_access_enable_ff};
  wire [31:0] rd_addr = {17'h00000, word_addr_ff};
  wire [31:0] rd_high = {27'h0000000, data_high_ff};
  wire [31:0] rd_wake = {5'h00, wake_pol_ff, 5'h00, wake_en_ff};
  wire [31:0] rd_mask = {irq_packet_always_send_ff, 11'h000, irq_gates_ff};
  wire [31:0] rd_data = hit_sel  ? rd_sel :
                        hit_addr ? rd_addr :
                        hit_low  ? data_low_ff :
                        hit_high ? rd_high :
                        hit_wake ? rd_wake :
                        hit_mask ? rd_mask : BUS_ERR_DATA;

  wire [PINS-1:0] img_en  = eeprom_present ? eeprom_wake_image[PINS-1:0] : '0;
  wire [PINS-1:0] img_pol = eeprom_present ?
                            eeprom_wake_image[WAKE_POL_LO +: PINS] : '0;

  wire [19:0] gated = irq_gates_ff & {mac_events, pin_sync_ff};

  ram_port_access u_seq (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .start        (start),
    .start_write  (start_wr),
    .ram_req_ff   (seq_req),
    .ram_rsp      (ram_rsp),
    .busy_ff      (port_busy),
    .read_done_ff ()
  );

  wake_pin_gate #(.PINS(PINS)) u_wake (
    .ref_clk       (ref_clk),
    .srst          (srst),
    .pin_level     (pin_sync_ff),
    .pin_is_gpio   (pin_is_gpio),
    .wake_enable   (wake_en_ff),
    .wake_polarity (wake_pol_ff),
    .wake_hit_ff   (wake_hit)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wb_rsp_ff <= '0;
    end else begin
      wb_rsp_ff.ack <= access & mapped;
      wb_rsp_ff.err <= access & ~mapped;
      wb_rsp_ff.dat <= rd_data;
    end
  end

  // Address, target and enable registers.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      word_addr_ff              <= RST_WORD_ADDRESS;
      target_ff                 <= RST_TARGET;
      ram_test_access_enable_ff <= 1'b0;
    end else begin
      if (wr_ok & hit_addr) begin
        word_addr_ff <= wb_req.dat[WORD_ADDR_W-1:0];
      end
      if (wr_ok & hit_sel) begin
        target_ff                 <= wb_req.dat[SEL_TARGET_LO +: 2];
        ram_test_access_enable_ff <= wb_req.dat[SEL_ENABLE_BIT];
      end
    end
  end

  // Data registers take the read result only when the access finishes.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_low_ff  <= RST_DATA_LOW;
      data_high_ff <= RST_DATA_HIGH;
    end else if (read_capture) begin
      data_low_ff  <= ram_rsp.rdata[31:0];
      data_high_ff <= ram_rsp.rdata[RAM_DATA_W-1:32];
    end else begin
      if (wr_ok & hit_low) begin
        data_low_ff <= wb_req.dat;
      end
      if (wr_ok & hit_high) begin
        data_high_ff <= wb_req.dat[HIGH_DATA_W-1:0];
      end
    end
  end

  // RAM request carries the latched address and data.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ram_req_ff <= '0;
    end else begin
      ram_req_ff.req    <= seq_req.req;
      ram_req_ff.write  <= seq_req.write;
      ram_req_ff.target <= ram_target_e'(target_ff);
      ram_req_ff.addr   <= word_addr_ff;
      ram_req_ff.wdata  <= {data_high_ff, data_low_ff};
    end
  end

  // Wake field and its EEPROM image.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wake_en_img_ff  <= '0;
      wake_pol_img_ff <= '0;
      wake_en_ff      <= '0;
      wake_pol_ff     <= '0;
    end else if (eeprom_loaded) begin
      wake_en_img_ff  <= img_en;
      wake_pol_img_ff <= img_pol;
      wake_en_ff      <= img_en;
      wake_pol_ff     <= img_pol;
    end else if (usb_or_lite_reset) begin
      wake_en_ff  <= eeprom_present ? wake_en_img_ff : '0;
      wake_pol_ff <= eeprom_present ? wake_pol_img_ff : '0;
    end else if (wr & hit_wake) begin
      wake_en_ff  <= wb_req.dat[WAKE_EN_LO +: PINS];
      wake_pol_ff <= wb_req.dat[WAKE_POL_LO +: PINS];
    end
  end

  // Interrupt report mask and packet decision.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_packet_always_send_ff <= 1'b0;
      irq_gates_ff              <= RST_IRQ_MASK;
      irq_report_sources_ff     <= '0;
      irq_packet_send_ff        <= 1'b0;
    end else begin
      if (wr & hit_mask) begin
        irq_packet_always_send_ff <= wb_req.dat[IRQ_ALWAYS_BIT];
        irq_gates_ff              <= wb_req.dat[IRQ_EVENT_W-1:0];
      end
      irq_report_sources_ff <= gated;
      irq_packet_send_ff <= irq_interval_tick & (irq_packet_always_send_ff | (|gated));
    end
  end

  // Pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_meta_ff   <= '0;
      pin_sync_ff   <= '0;
      wake_hit_ff   <= '0;
      wake_event_ff <= 1'b0;
    end else begin
      pin_meta_ff   <= pin_level;
      pin_sync_ff   <= pin_meta_ff;
      // Registered wake outputs.
      wake_hit_ff   <= wake_hit;
      wake_event_ff <= |wake_hit;
    end
  end

endmodule

// file: ram_port_regs_chk_sva.sv
// Concurrent checks on the ports of the RAM port register bank.
module ram_port_regs_chk #(
  parameter int unsigned PINS = 11
) (
  // Clock and reset.
  input wire logic                   ref_clk,
  input wire logic                   srst,
  // Bus and RAM side.
  input wire ram_port_pkg::wb_req_s  wb_req,
  input wire ram_port_pkg::wb_rsp_s  wb_rsp_ff,
  input wire ram_port_pkg::ram_req_s ram_req_ff,
  input wire ram_port_pkg::ram_rsp_s ram_rsp,
  input wire logic                   ram_test_access_enable_ff,
  // Pins and report.
  input wire logic [PINS-1:0]        pin_is_gpio,
  input wire logic [PINS-1:0]        wake_hit_ff,
  input wire logic [8:0]             mac_events,
  input wire logic                   irq_interval_tick,
  input wire logic                   irq_packet_send_ff,
  input wire logic [19:0]            irq_report_sources_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  import ram_port_pkg::*;
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic pend_ff;
  logic nxt_pend;
  wire  take = wb_req.cyc && wb_req.stb && !wb_rsp_ff.ack && !wb_rsp_ff.err;
  wire  busy_rd = take && !wb_req.we && wb_req.adr == OFS_PORT_SELECT && pend_ff && !ram_rsp.done;
  wire  mapped = wb_req.adr inside {OFS_PORT_SELECT, OFS_PORT_COMMAND, OFS_WORD_ADDRESS,
                                    OFS_DATA_LOW, OFS_DATA_HIGH, OFS_PIN_WAKE, OFS_IRQ_MASK};
  // The RAM's done is the only thing that ends a pending access.
  assign nxt_pend = ram_req_ff.req | (pend_ff & ~ram_rsp.done);
  always_ff @(posedge ref_clk) begin
    pend_ff <= srst ? 1'b0 : nxt_pend;
  end
  bus_answer_a: assert property (take |=> wb_rsp_ff.ack ^ wb_rsp_ff.err)
    else $error("bus request not answered next cycle");
  unmapped_err_a: assert property (take && !mapped |=> wb_rsp_ff.err && !wb_rsp_ff.ack)
    else $error("unmapped access not refused");
  ack_pulse_a: assert property (wb_rsp_ff.ack |=> !wb_rsp_ff.ack)
    else $error("ack held too long");
  ram_pulse_a: assert property (ram_req_ff.req |=> !ram_req_ff.req)
    else $error("ram request longer than one cycle");
  test_gate_a: assert property (ram_req_ff.req |-> ram_test_access_enable_ff)
    else $error("ram access without test mode");
  one_pending_a: assert property (ram_req_ff.req |-> !pend_ff)
    else $error("second ram request while one pending");
  busy_read_a: assert property (wb_rsp_ff.ack && $past(busy_rd) |-> !wb_rsp_ff.dat[31])
    else $error("port reads ready during an access");
  wake_gpio_a: assert property ((wake_hit_ff & ~$past(pin_is_gpio, 2)) == '0)
    else $error("wake from a pin not in gpio mode");
  packet_tick_a: assert property (irq_packet_send_ff |-> $past(irq_interval_tick))
    else $error("packet sent without interval tick");
  source_gate_a: assert property ((irq_report_sources_ff[19:11] & ~$past(mac_events)) == '0)
    else $error("report source without its event");
  cover property (ram_req_ff.req && ram_req_ff.write);
  cover property (irq_packet_send_ff);
  cover property (|wake_hit_ff);
endmodule

bind ram_port_and_irq_report_regs ram_port_regs_chk #(.PINS(PINS)) u_chk (
  .ref_clk, .srst, .wb_req, .wb_rsp_ff, .ram_req_ff, .ram_rsp, .ram_test_access_enable_ff,
  .pin_is_gpio, .wake_hit_ff, .mac_events, .irq_interval_tick, .irq_packet_send_ff,
  .irq_report_sources_ff);

// file: tb_ram_port_and_irq_report_regs.sv
// Self-checking bench for the RAM port register bank.
module tb_ram_port_and_irq_report_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import ram_port_pkg::*;
  typedef struct {
    logic        err;
    logic [31:0] mask;
    logic [31:0] exp;
  } note_s;
  note_s       notes[$];
  note_s       nt;
  int          errors = 0;
  int          total_checks = 0;
  int          t;
  int          i;
  logic [31:0] seed = 32'h3a0e;
  logic [31:0] rd, a, d, h, m, ev, img;
  logic [63:0] rr;
  logic        seen;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        usb_rst = 1'b0;
  wb_req_s     wb_req = '0;
  wb_rsp_s     wb_rsp;
  logic        eeprom_present = 1'b0;
  logic        eeprom_loaded = 1'b0;
  logic [31:0] eeprom_img = '0;
  ram_req_s    ram_req;
  ram_rsp_s    ram_rsp = '0;
  logic        test_en;
  logic [10:0] pin_level = '0;
  logic [10:0] pin_is_gpio = '0;
  logic [10:0] wake_hit;
  logic        wake_event;
  logic [8:0]  mac_events = '0;
  logic        irq_tick = 1'b0;
  logic        irq_send;
  logic [19:0] irq_src;
  logic [7:0]  ofs[6] = '{OFS_PORT_COMMAND, OFS_WORD_ADDRESS, OFS_DATA_LOW, OFS_DATA_HIGH,
                          OFS_PIN_WAKE, OFS_IRQ_MASK};
  logic [31:0] msk[6] = '{32'h0, 32'h7fff, 32'hffffffff, 32'h1f, 32'h07ff07ff, 32'h800fffff};
  logic [31:0] wv[3] = '{32'h07ff07ff, 32'h000007ff, 32'h07ff0000};
  logic [10:0] wh[3] = '{11'h0f0, 11'h000, 11'h000};

  ram_port_and_irq_report_regs u_dut (
    .ref_clk(ref_clk), .srst(srst), .usb_or_lite_reset(usb_rst), .wb_req(wb_req),
    .wb_rsp_ff(wb_rsp), .eeprom_present(eeprom_present), .eeprom_loaded(eeprom_loaded),
    .eeprom_wake_image(eeprom_img), .ram_req_ff(ram_req), .ram_rsp(ram_rsp),
    .ram_test_access_enable_ff(test_en), .pin_level(pin_level), .pin_is_gpio(pin_is_gpio),
    .wake_hit_ff(wake_hit), .wake_event_ff(wake_event), .mac_events(mac_events),
    .irq_interval_tick(irq_tick), .irq_packet_send_ff(irq_send),
    .irq_report_sources_ff(irq_src));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string what, input logic [39:0] e, input logic [39:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic guard(input logic ok);
    if (ok !== 1'b1) begin
      chk("wait bound", 1, 0);
      close_out();
    end
  endtask
  // The request stands until the rising edge that sees the answer; data is taken there.
  task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] wd,
                     input logic [31:0] mk, input logic [31:0] ex, input logic er);
    int n;
    notes.push_back('{er, mk, ex});
    @(posedge ref_clk);
    wb_req <= '{1'b1, 1'b1, w, 4'hf, ad, wd};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!(wb_rsp.ack || wb_rsp.err) && n < 20);
    guard(wb_rsp.ack || wb_rsp.err);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    bus(ad, 1'b1, wd, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rdx(input logic [7:0] ad, input logic [31:0] mk, input logic [31:0] ex);
    bus(ad, 1'b0, 32'h0, mk, ex, 1'b0);
  endtask

  always @(negedge ref_clk) begin
    if (wb_rsp.ack === 1'b1 || wb_rsp.err === 1'b1) begin
      nt = notes.pop_front();
      chk("bus error flag", nt.err, wb_rsp.err);
      if (nt.mask != 0)
        chk("read data", nt.exp, wb_rsp.dat & nt.mask);
    end
  end
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    rdx(OFS_PORT_SELECT, 32'hffffffff, 32'h80000000);
    for (i = 0; i < 6; i++)
      rdx(ofs[i], 32'hffffffff, 32'h0);
    $display("test reset values done");
    // Command writes here are acknowledged but start no access, since test mode is still off.
    for (i = 0; i < 6; i++) begin
      d = rnd();
      wr(ofs[i], d);
      rdx(ofs[i], 32'hffffffff, d & msk[i]);
    end
    bus(8'h54, 1'b0, 32'h0, 32'h0, 32'h0, 1'b1);
    bus(8'h00, 1'b1, rnd(), 32'h0, 32'h0, 1'b1);
    $display("test access kinds done");
    for (t = 0; t < 4; t++) begin
      a = rnd();
      d = rnd();
      h = rnd();
      rr = {rnd(), rnd()};
      wr(OFS_PORT_SELECT, {29'h0, t[1:0], 1'b1});
      wr(OFS_WORD_ADDRESS, a);
      wr(OFS_DATA_LOW, d);
      wr(OFS_DATA_HIGH, h);
      wr(OFS_PORT_COMMAND, {31'h0, t[0]});
      i = 0;
      do begin
        @(negedge ref_clk);
        i++;
      end while (ram_req.req !== 1'b1 && i < 20);
      guard(ram_req.req);
      chk("test enable", 1'b1, test_en);
      chk("ram request", {t[0], t[1:0], a[14:0]}, {ram_req.write, ram_req.target, ram_req.addr});
      if (t[0])
        chk("ram write data", {h[4:0], d}, ram_req.wdata);
      rdx(OFS_PORT_SELECT, 32'h80000007, {29'h0, t[1:0], 1'b1});
      rdx(OFS_DATA_LOW, 32'hffffffff, d);
      repeat (t) @(posedge ref_clk);
      ram_rsp <= '{1'b1, rr[36:0]};
      @(posedge ref_clk);
      ram_rsp <= '{1'b0, ~rr[36:0]};
      i = 0;
      do begin
        bus(OFS_PORT_SELECT, 1'b0, 32'h0, 32'h0, 32'h0, 1'b0);
        i++;
      end while (rd[31] !== 1'b1 && i < 20);
      guard(rd[31]);
      rdx(OFS_DATA_LOW, 32'hffffffff, t[0] ? d : rr[31:0]);
      rdx(OFS_DATA_HIGH, 32'hffffffff, {27'h0, t[0] ? h[4:0] : rr[36:32]});
    end
    $display("test ram port done");
    for (i = 0; i < 11; i++) begin
      m = (i < 9) ? 32'h800 << i : (i == 9) ? 32'h80000000 : 32'h0;
      ev = (i < 9) ? rnd() | (32'h1 << i) : (i == 9) ? 32'h0 : 32'h1ff;
      wr(OFS_IRQ_MASK, m);
      mac_events <= ev[8:0];
      repeat (3) @(posedge ref_clk);
      irq_tick <= 1'b1;
      @(posedge ref_clk);
      irq_tick <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
        @(negedge ref_clk);
        seen = seen | irq_send;
      end
      chk("report sources", m[19:0] & {ev[8:0], 11'h0}, irq_src);
      chk("packet sent", i < 10, seen);
    end
    $display("test report mask done");
    img = rnd();
    @(posedge ref_clk);
    eeprom_present <= 1'b1;
    eeprom_img <= img;
    eeprom_loaded <= 1'b1;
    @(posedge ref_clk);
    eeprom_loaded <= 1'b0;
    rdx(OFS_PIN_WAKE, 32'hffffffff, img & 32'h07ff07ff);
    pin_is_gpio <= 11'h0f0;
    pin_level <= 11'h7ff;
    for (i = 0; i < 3; i++) begin
      wr(OFS_PIN_WAKE, wv[i]);
      repeat (6) @(negedge ref_clk);
      chk("wake hits", wh[i], wake_hit);
      chk("wake event", wh[i] != 0, wake_event);
    end
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      eeprom_present <= (i == 0);
      @(posedge ref_clk);
      usb_rst <= 1'b1;
      @(posedge ref_clk);
      usb_rst <= 1'b0;
      rdx(OFS_PIN_WAKE, 32'hffffffff, i == 0 ? img & 32'h07ff07ff : 32'h0);
    end
    $display("test pin wake done");
    close_out();
  end
endmodule
